/* verilog/cgc_pkg.sv */
package cgc_pkg;
   // ------------------------------------------------------------
   // Register map and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] CGC_GENERAL_CONTROL_ADDR = 8'hab;
   localparam logic [7:0] CGC_GENERAL_CONTROL_RESET = 8'h00;
   localparam int CGC_ABORT_BIT = 7;
   localparam int CGC_OVERLOAD_BIT = 6;
   localparam int CGC_TIME_TRIG_BIT = 5;
   localparam int CGC_CAPTURE_BIT = 4;
   localparam int CGC_LISTEN_BIT = 3;
   localparam int CGC_TEST_BIT = 2;
   localparam int CGC_ENABLE_BIT = 1;
   localparam int CGC_SOFT_RESET_BIT = 0;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CGC_START_PERIODS = 2;
   localparam logic [1:0] CGC_START_CYCLES = 2'(CGC_START_PERIODS);

   // Controller activity state
   typedef enum logic [1:0] {CGC_STANDBY, CGC_STARTING, CGC_RUNNING, CGC_DRAINING} cgc_state_t;

   // Events reported by the protocol engine
   typedef struct packed {
      logic frameBusy;
      logic overloadStart;
      logic startOfFrame;
      logic endOfFrameLast;
   } cgc_events_t;

   // Mode controls driven to the protocol engine
   typedef struct packed {
      logic abortAll;
      logic overloadReq;
      logic timeTriggeredMode;
      logic captureAtFrameEnd;
      logic listenOnly;
      logic factoryTest;
      logic singleShot;
      logic noAck;
      logic freezeErrCounters;
   } cgc_modes_t;
endpackage

/* verilog/cgc_general_control.sv */
`timescale 1ns/10ps
`default_nettype none
module cgc_general_control
   import cgc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   output logic [7:0] sfrRdata,
   input wire cgc_events_t engineEvents,
   input wire logic canRxPin,
   output cgc_modes_t modes,
   output logic controllerClockEnable,
   output logic controllerRun,
   output logic receiverActive,
   output logic canTxPin,
   input wire logic engineTx,
   output logic channelEnableClear,
   output logic softResetPulse,
   output logic timerRun,
   output logic timerCaptureStrobe,
   output logic enabledStateFlag,
   output logic canRxSync
);
   // ------------------------------------------------------------
   // Register address decode
   // ------------------------------------------------------------
   function automatic logic hitReg(input logic [7:0] a);
      return a == CGC_GENERAL_CONTROL_ADDR;
   endfunction

   logic [7:0] ctrl_q, ctrl_d;
   logic rxMeta_q, rxSync_q;
   logic softRst_q, softRst_d;
   cgc_state_t state_q, state_d;
   logic [1:0] startCnt_q, startCnt_d;
   logic [7:0] rdata_q, rdata_d;
   logic txOut_q, txOut_d;
   logic capture_q, capture_d;
   logic clkEn_q, clkEn_d;
   logic run_q, run_d;
   logic wr;

   assign wr = sfrWrite && hitReg(sfrAddr);

   // ------------------------------------------------------------
   // Control register next value; overload set wins over clear
   // ------------------------------------------------------------
   always_comb begin
      ctrl_d = ctrl_q;
      softRst_d = 1'h0;
      if (softRst_q) begin
         ctrl_d = CGC_GENERAL_CONTROL_RESET;
      end else begin
         if (wr) begin
            ctrl_d = sfrWdata;
            ctrl_d[CGC_SOFT_RESET_BIT] = 1'h0;
            softRst_d = sfrWdata[CGC_SOFT_RESET_BIT];
         end
         if (engineEvents.overloadStart && !(wr && sfrWdata[CGC_OVERLOAD_BIT])) begin
            ctrl_d[CGC_OVERLOAD_BIT] = 1'h0;
         end
      end
   end

   // Control register and soft reset; the pulse lives one cycle only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= CGC_GENERAL_CONTROL_RESET;
         softRst_q <= 1'h0;
      end else begin
         ctrl_q <= ctrl_d;
         softRst_q <= softRst_d;
      end
   end

   // Enable sequencing: two-period start, drain to frame end on disable
   always_comb begin
      state_d = state_q;
      startCnt_d = startCnt_q;
      unique case (state_q)
         CGC_STANDBY: begin
            if (ctrl_q[CGC_ENABLE_BIT]) begin
               state_d = CGC_STARTING;
               startCnt_d = CGC_START_CYCLES - 2'h1;
            end
         end
         CGC_STARTING: begin
            if (!ctrl_q[CGC_ENABLE_BIT]) begin
               state_d = CGC_STANDBY;
            end else if (startCnt_q == 2'h0) begin
               state_d = CGC_RUNNING;
            end else begin
               startCnt_d = startCnt_q - 2'h1;
            end
         end
         CGC_RUNNING: begin
            if (!ctrl_q[CGC_ENABLE_BIT]) begin
               state_d = CGC_DRAINING;
            end
         end
         CGC_DRAINING: begin
            if (ctrl_q[CGC_ENABLE_BIT]) begin
               state_d = CGC_RUNNING;
            end else if (!engineEvents.frameBusy) begin
               state_d = CGC_STANDBY;
            end
         end
      endcase
      if (softRst_q) begin
         state_d = CGC_STANDBY;
      end
      // Status flags follow the next state, so each leaves a flop
      clkEn_d = (state_d != CGC_STANDBY);
      run_d = (state_d == CGC_RUNNING) || (state_d == CGC_DRAINING);
   end

   // Sequencer state, start counter and status flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= CGC_STANDBY;
         startCnt_q <= 2'h0;
         clkEn_q <= 1'h0;
         run_q <= 1'h0;
      end else begin
         state_q <= state_d;
         startCnt_q <= startCnt_d;
         clkEn_q <= clkEn_d;
         run_q <= run_d;
      end
   end

   // Output path: transmit gating, capture select, read data
   always_comb begin
      logic active;
      active = (state_q == CGC_RUNNING) || (state_q == CGC_DRAINING);
      // Listening node never drives dominant, so forcing recessive is safe
      txOut_d = active && !ctrl_q[CGC_LISTEN_BIT] ? engineTx : 1'h1;
      capture_d = ctrl_q[CGC_TIME_TRIG_BIT] && active &&
                  (ctrl_q[CGC_CAPTURE_BIT] ? engineEvents.endOfFrameLast
                                           : engineEvents.startOfFrame);
      rdata_d = rdata_q;
      if (sfrRead && hitReg(sfrAddr)) begin
         rdata_d = ctrl_q;
         rdata_d[CGC_SOFT_RESET_BIT] = softRst_q;
      end
   end

   // ------------------------------------------------------------
   // Output flops: read data, transmit pin, capture strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= CGC_GENERAL_CONTROL_RESET;
         txOut_q <= 1'h1;
         capture_q <= 1'h0;
      end else begin
         rdata_q <= rdata_d;
         txOut_q <= txOut_d;
         capture_q <= capture_d;
      end
   end

   // Receive pin synchroniser; idles recessive so no false edge after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxMeta_q <= 1'h1;
         rxSync_q <= 1'h1;
      end else begin
         rxMeta_q <= canRxPin;
         rxSync_q <= rxMeta_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flip-flops
   // ------------------------------------------------------------
   assign sfrRdata = rdata_q;
   assign canTxPin = txOut_q;
   assign canRxSync = rxSync_q;
   assign timerCaptureStrobe = capture_q;
   assign softResetPulse = softRst_q;
   assign channelEnableClear = ctrl_q[CGC_ABORT_BIT];
   assign modes.abortAll = ctrl_q[CGC_ABORT_BIT];
   assign modes.overloadReq = ctrl_q[CGC_OVERLOAD_BIT];
   assign modes.timeTriggeredMode = ctrl_q[CGC_TIME_TRIG_BIT];
   assign modes.captureAtFrameEnd = ctrl_q[CGC_CAPTURE_BIT];
   assign modes.listenOnly = ctrl_q[CGC_LISTEN_BIT];
   assign modes.factoryTest = ctrl_q[CGC_TEST_BIT];
   assign modes.singleShot = ctrl_q[CGC_TIME_TRIG_BIT];
   assign modes.noAck = ctrl_q[CGC_LISTEN_BIT];
   assign modes.freezeErrCounters = ctrl_q[CGC_LISTEN_BIT];
   // Clock gate and run flags come from the sequencer's status flops
   assign controllerClockEnable = clkEn_q;
   assign controllerRun = run_q;
   // Receiver stays on while draining so a frame being received completes
   assign receiverActive = run_q;
   assign timerRun = run_q;
   assign enabledStateFlag = run_q;
endmodule
`default_nettype wire

/* tb/cgc_can_bus.sv */
`timescale 1ns/10ps
`default_nettype none
module cgc_can_bus (
   input wire logic nodeTx,
   input wire logic otherDominant,
   output logic busLevel
);
   // Wired-AND bus; the pull-up keeps it recessive when nobody drives
   assign busLevel = nodeTx & ~otherDominant;
endmodule
`default_nettype wire

/* tb/cgc_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module cgc_checker
   import cgc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   input wire logic sfrWrite,
   input wire cgc_events_t engineEvents,
   input wire cgc_modes_t modes,
   input wire logic controllerClockEnable,
   input wire logic controllerRun,
   input wire logic receiverActive,
   input wire logic canTxPin,
   input wire logic channelEnableClear,
   input wire logic softResetPulse,
   input wire logic timerCaptureStrobe,
   input wire logic enabledStateFlag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Control register write decode
   logic wr;
   assign wr = sfrWrite && sfrAddr == CGC_GENERAL_CONTROL_ADDR;
   // Properties, with the capture event chosen by the select bit
   abort_set_a: assert property (wr && sfrWdata[7] && !softResetPulse |=> channelEnableClear)
      else $error("abort missing");
   abort_hold_a: assert property (channelEnableClear && !wr && !softResetPulse |=> channelEnableClear)
      else $error("abort dropped");
   overload_clear_a: assert property (modes.overloadReq && engineEvents.overloadStart && !wr
      |=> !modes.overloadReq) else $error("overload kept");
   capture_point_a: assert property (modes.timeTriggeredMode && enabledStateFlag && (modes.captureAtFrameEnd ?
      engineEvents.endOfFrameLast : engineEvents.startOfFrame) |=> timerCaptureStrobe) else $error("no capture");
   capture_idle_a: assert property (!modes.timeTriggeredMode |=> !timerCaptureStrobe) else $error("stray capture");
   listen_quiet_a: assert property (modes.listenOnly |=> canTxPin) else $error("listen sent");
   standby_tx_a: assert property (!controllerRun |-> !receiverActive ##1 canTxPin) else $error("standby");
   start_delay_a: assert property (wr && sfrWdata[1:0] == 2'h2 && !controllerClockEnable
      |=> !enabledStateFlag [*3] ##1 enabledStateFlag) else $error("start delay");
   soft_reset_a: assert property (wr && sfrWdata[0] && !softResetPulse
      |=> softResetPulse ##1 (modes == '0 && !controllerClockEnable)) else $error("soft reset");
   // Main scenarios reached
   cover property (wr && sfrWdata[0]);
   cover property (timerCaptureStrobe);
   cover property (controllerRun && engineEvents.frameBusy);
   cover property (modes.listenOnly && controllerRun);
endmodule
bind cgc_general_control cgc_checker chk (.clk, .resetn, .sfrAddr, .sfrWdata, .sfrWrite, .engineEvents,
   .modes, .controllerClockEnable, .controllerRun, .receiverActive, .canTxPin, .channelEnableClear,
   .softResetPulse, .timerCaptureStrobe, .enabledStateFlag);
`default_nettype wire

/* tb/tb_can_general_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_can_general_control
   import cgc_pkg::*;
;
   logic clk = 1'h0, resetn = 1'h0, sfrWrite = 1'h0, sfrRead = 1'h0, engineTx = 1'h1, otherDom = 1'h0;
   logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, rnd = 8'h3c;
   logic controllerClockEnable, controllerRun, receiverActive, canTxPin, canRxPin, canRxSync;
   logic channelEnableClear, softResetPulse, timerRun, timerCaptureStrobe, enabledStateFlag;
   cgc_events_t ev = '0;
   cgc_modes_t modes;
   int error_cnt = 0, checks = 0;
   cgc_general_control DUT (.clk, .resetn, .sfrAddr, .sfrWdata, .sfrWrite, .sfrRead, .sfrRdata,
      .engineEvents(ev), .canRxPin, .modes, .controllerClockEnable, .controllerRun, .receiverActive,
      .canTxPin, .engineTx, .channelEnableClear, .softResetPulse, .timerRun, .timerCaptureStrobe,
      .enabledStateFlag, .canRxSync);
   cgc_can_bus BUS (.nodeTx(canTxPin), .otherDominant(otherDom), .busLevel(canRxPin));
   // Random source, fixed start so runs repeat
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   // Mode outputs expected from a control byte; single shot follows
   // time-triggered mode, listen mode also mutes ack and error counters
   function automatic cgc_modes_t expModes(input logic [7:0] r);
      return '{r[CGC_ABORT_BIT], r[CGC_OVERLOAD_BIT], r[CGC_TIME_TRIG_BIT], r[CGC_CAPTURE_BIT], r[CGC_LISTEN_BIT],
               r[CGC_TEST_BIT], r[CGC_TIME_TRIG_BIT], r[CGC_LISTEN_BIT], r[CGC_LISTEN_BIT]};
   endfunction
   task automatic chkModes(input cgc_modes_t got, input cgc_modes_t exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t modes %h exp %h", $time, got, exp);
      end
   endtask
   // Strobes held one edge, dropped at the next falling edge
   task automatic wr(input logic [7:0] d, input logic [7:0] a = CGC_GENERAL_CONTROL_ADDR);
      sfrAddr = a;
      sfrWdata = d;
      sfrWrite = 1'h1;
      @(negedge clk);
      sfrWrite = 1'h0;
   endtask
   task automatic rd(input logic [7:0] exp);
      sfrAddr = CGC_GENERAL_CONTROL_ADDR;
      sfrRead = 1'h1;
      @(negedge clk);
      sfrRead = 1'h0;
      @(negedge clk);
      chk(sfrRdata, exp);
   endtask
   task automatic finish_test();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Clock and watchdog; the run needs well under a thousand cycles
   initial forever #2 clk = ~clk;
   initial begin
      #20000;
      error_cnt++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'h1;
      rd(8'h00);
      chk1(canTxPin, 1'h1);
      wr(8'h02, 8'h5a);
      rd(8'h00);
      wr(8'h02);
      repeat (2) @(negedge clk);
      chk1(enabledStateFlag, 1'h0);
      chk1(timerRun, 1'h0);
      @(negedge clk);
      chk1(enabledStateFlag, 1'h1);
      chk1(controllerClockEnable, 1'h1);
      chk1(timerRun, 1'h1);
      wr(8'h82);
      repeat (5) @(negedge clk);
      chk1(channelEnableClear, 1'h1);
      wr(8'h42);
      rd(8'h42);
      ev.overloadStart = 1'h1;
      @(negedge clk);
      ev.overloadStart = 1'h0;
      rd(8'h02);
      for (int i = 0; i < 8; i++) begin
         wr({2'h0, !i[2], i[1], 4'h2});
         ev.startOfFrame = i[0];
         ev.endOfFrameLast = !i[0];
         @(negedge clk);
         ev = '0;
         chk1(timerCaptureStrobe, (i[0] ^ i[1]) & !i[2]);
      end
      engineTx = 1'h0;
      wr(8'h0a);
      otherDom = 1'h1;
      repeat (3) @(negedge clk);
      chk1(canTxPin, 1'h1);
      chk1(canRxSync, 1'h0);
      otherDom = 1'h0;
      wr(8'h02);
      @(negedge clk);
      chk1(canTxPin, 1'h0);
      ev.frameBusy = 1'h1;
      wr(8'h00);
      repeat (3) @(negedge clk);
      chk1(controllerRun, 1'h1);
      chk1(receiverActive, 1'h1);
      ev.frameBusy = 1'h0;
      repeat (3) @(negedge clk);
      chk1(receiverActive, 1'h0);
      chk1(canTxPin, 1'h1);
      wr(8'h02);
      repeat (3) @(negedge clk);
      wr(8'h01);
      chk1(softResetPulse, 1'h1);
      rd(8'h01);
      chk1(controllerClockEnable, 1'h0);
      rd(8'h00);
      repeat (20) begin
         rnd = lfsr(rnd);
         wr(rnd & 8'hf8 | 8'h02);
         rd(rnd & 8'hf8 | 8'h02);
         chkModes(modes, expModes(rnd & 8'hf8 | 8'h02));
      end
      finish_test();
   end
endmodule
`default_nettype wire
